/* qec_ctrl.sv */
// Multi-axis quadrature counter control: command decode, counters,
// filter dividers, flag outputs and shared interrupt.
// Assumes one-cycle i_wr/i_rd strobes synchronous to i_clk.
`include "qec_consts.svh"
module qec_ctrl import qec_pkg::*; #(
  parameter int NUM_AXES = 4            // Two or four axes
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  input  wire logic [3:0]            i_addr,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  input  wire logic [7:0]            i_wdata,
  output logic [7:0]                 o_rdata,
  input  wire logic                  i_axis_sel,
  input  wire logic                  i_filter_base_clock,
  input  wire logic [NUM_AXES-1:0]   i_enc_a,
  input  wire logic [NUM_AXES-1:0]   i_enc_b,
  input  wire logic [NUM_AXES-1:0]   i_enc_idx,
  input  wire logic [2*NUM_AXES-1:0] i_flag_a_sel,
  input  wire logic [2*NUM_AXES-1:0] i_flag_b_sel,
  input  wire logic [NUM_AXES-1:0]   i_gate_mode,
  input  wire logic [3*NUM_AXES-1:0] i_load_cause_jumper,
  input  wire logic [3*NUM_AXES-1:0] i_reset_cause_jumper,
  input  wire logic [3*NUM_AXES-1:0] i_irq_cause_jumper,
  output logic [NUM_AXES-1:0]        o_flag_output_a,
  output logic [NUM_AXES-1:0]        o_flag_output_b,
  output logic                       o_irq
);
  // ==========================================================
  // Elaboration check
  if (NUM_AXES != 2 && NUM_AXES != 4) begin : g_bad
    $error("NUM_AXES must be 2 or 4");
  end

  // ==========================================================
  // Shared decode
  logic                fbc_q;            // Base clock last level
  logic                fbc_tick;         // Base clock rising edge
  logic [NUM_AXES-1:0] irq_src_q;        // Sticky source bits
  logic [NUM_AXES-1:0] irq_rise;         // Per-axis cause edge
  logic [NUM_AXES-1:0] ctl_wr;           // Command write per axis
  logic [NUM_AXES-1:0] dat_wr;           // Data write per axis
  logic [NUM_AXES-1:0] dat_rd;           // Data read per axis
  logic [NUM_AXES-1:0] ctl_rd;           // Flag byte read per axis
  logic [7:0]          flag_byte [NUM_AXES]; // Status per axis
  logic [7:0]          data_byte [NUM_AXES]; // Snapshot byte per axis
  logic                irq_clr;          // Clear access seen
  logic [7:0]          rdata_d;          // Read mux

  assign fbc_tick = i_filter_base_clock & ~fbc_q;
  assign irq_clr  = (i_rd | i_wr) &
                    (i_addr == `QEC_OFS_IRQ_CLR);

  // Per-axis strobes from address, pair and selection
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      logic hit;
      logic own;
      hit = (i_addr & `QEC_OFS_PAIR_MASK) ==
            (`QEC_OFS_DATA0 + 4'(`QEC_OFS_PAIR_STEP * (a / 2)));
      own = (i_axis_sel == a[0]);
      // Pair-wide when bit 7 set, else the selected axis
      ctl_wr[a] = i_wr & hit & i_addr[`QEC_OFS_CTRL_BIT] &
                  (i_wdata[`QEC_CMD_BOTH] | own);
      ctl_rd[a] = i_rd & hit & i_addr[`QEC_OFS_CTRL_BIT] & own;
      dat_wr[a] = i_wr & hit & ~i_addr[`QEC_OFS_CTRL_BIT] & own;
      dat_rd[a] = i_rd & hit & ~i_addr[`QEC_OFS_CTRL_BIT] & own;
    end
  end

  // Read data selection; unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    if (i_addr == `QEC_OFS_IRQ_SRC) begin
      rdata_d = 8'(irq_src_q);
    end
    for (int a = 0; a < NUM_AXES; a++) begin
      if (ctl_rd[a]) begin
        rdata_d = flag_byte[a];
      end
      if (dat_rd[a]) begin
        rdata_d = data_byte[a];
      end
    end
  end

  // Read data is registered: valid the cycle after i_rd
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end
  end

  // Base clock edge detect
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fbc_q <= 1'b0;
    end else begin
      fbc_q <= i_filter_base_clock;
    end
  end

  // Sticky sources; a new event beats a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_src_q <= '0;
    end else begin
      irq_src_q <= (irq_src_q & ~{NUM_AXES{irq_clr}}) |
                   irq_rise;
    end
  end

  assign o_irq = |irq_src_q;

  // ==========================================================
  // BCD or binary single step
  function automatic logic [23:0] qec_step(input logic [23:0] v,
                                           input logic up,
                                           input logic bcd);
    logic [23:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    if (!bcd) begin
      r = up ? v + 24'h1 : v - 24'h1;
    end else begin
      for (int i = 0; i < `QEC_BCD_DIGITS; i++) begin
        if (c) begin
          if (up && v[4*i +: 4] == `QEC_BCD_NINE) begin
            r[4*i +: 4] = 4'h0;
          end else if (!up && v[4*i +: 4] == 4'h0) begin
            r[4*i +: 4] = `QEC_BCD_NINE;
          end else begin
            r[4*i +: 4] = up ? v[4*i +: 4] + 4'h1 : v[4*i +: 4] - 4'h1;
            c = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : qec_step

  // ==========================================================
  // Per-axis counter channel
  for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
    logic [7:0]  cmr_q;        // Counter mode byte
    logic [1:0]  bp_q;         // Byte pointer
    logic [23:0] preset_q;     // Reload value
    logic [23:0] cnt_q;        // Position counter
    logic [23:0] snap_q;       // Snapshot latch
    logic [7:0]  psc_n_q;      // Divider factor
    logic [7:0]  psc_q;        // Divider count
    logic [1:0]  ab_q;         // Filtered A/B
    logic        bt_q, ct_q, cpt_q, sign_q, err_q, up_q, dis_q;
    logic        fa_q, fb_q;   // Flag output registers
    logic [2:0]  cause_q;      // Last cause levels
    logic        sample;       // Filter sample strobe
    logic        ev, up, bad, go;
    logic        carry, borrow, cmp;
    logic [23:0] cnt_d, lim;
    logic [2:0]  srcs, ld_c, rs_c, iq_c;
    qec_count_mode_t mode;
    qec_quad_t       quad;
    qec_xfer_t       xf;
    logic        rl;           // Reset/load command strobe
    logic [1:0]  clr;

    assign mode = qec_count_mode_t'(cmr_q[`QEC_CM_MODE_HI:`QEC_CM_MODE_LO]);
    assign quad = qec_quad_t'(cmr_q[`QEC_CM_QUAD_HI:`QEC_CM_QUAD_LO]);
    assign rl   = ctl_wr[g] & (qec_regsel_t'(i_wdata[`QEC_CMD_REG_HI:
                  `QEC_CMD_REG_LO]) == QEC_REG_RESET_LOAD);
    assign xf   = qec_xfer_t'(i_wdata[`QEC_RL_XFR_HI:`QEC_RL_XFR_LO]);
    assign clr  = rl ? i_wdata[`QEC_RL_CLR_HI:`QEC_RL_CLR_LO] : 2'h0;

    // Divider ticks every n+1 base clocks
    assign sample = fbc_tick & (psc_q == 8'h00);

    // Quadrature decode against last filtered sample
    always_comb begin
      logic da;
      logic db;
      da  = i_enc_a[g] ^ ab_q[1];
      db  = i_enc_b[g] ^ ab_q[0];
      ev  = 1'b0;
      up  = 1'b1;
      bad = 1'b0;
      case (quad)
        QEC_Q_NONQUAD: begin
          ev = da & i_enc_a[g];
          up = i_enc_b[g];
        end
        QEC_Q_X1: begin
          ev = da & ~i_enc_b[g];
          up = i_enc_a[g];
        end
        QEC_Q_X2: begin
          ev = da;
          up = i_enc_a[g] ^ i_enc_b[g];
        end
        default: begin
          ev = da ^ db;
          up = da ? (i_enc_a[g] ^ i_enc_b[g]) : ~(i_enc_a[g] ^ i_enc_b[g]);
        end
      endcase
      bad = sample & da & db & (quad != QEC_Q_NONQUAD);
      ev  = ev & sample;
    end

    // Cause routing: flag A, flag B, index
    assign srcs = {fa_q, fb_q, i_enc_idx[g]};
    assign ld_c = srcs & i_load_cause_jumper[3*g +: 3];
    assign rs_c = srcs & i_reset_cause_jumper[3*g +: 3];
    assign iq_c = srcs & i_irq_cause_jumper[3*g +: 3];
    assign irq_rise[g] = |iq_c & ~|(cause_q & i_irq_cause_jumper[3*g +: 3]);

    // Gate mode enables counting; otherwise the input resets
    assign go = ev & ~dis_q & (~i_gate_mode[g] | |rs_c);

    // Next count and boundary events
    always_comb begin
      lim    = cmr_q[`QEC_CM_BCD] ? `QEC_BCD_MAX : `QEC_BIN_MAX;
      cnt_d  = qec_step(cnt_q, up, cmr_q[`QEC_CM_BCD]);
      carry  = 1'b0;
      borrow = 1'b0;
      case (mode)
        QEC_CM_RANGE: begin
          if (up && cnt_q == preset_q) cnt_d = cnt_q;
          if (!up && cnt_q == 24'h0) cnt_d = cnt_q;
        end
        QEC_CM_MODULO: begin
          carry  = up & (cnt_q == preset_q);
          borrow = ~up & (cnt_q == 24'h0);
          if (carry) cnt_d = 24'h0;
          if (borrow) cnt_d = preset_q;
        end
        default: begin
          carry  = up & (cnt_q == lim);
          borrow = ~up & (cnt_q == 24'h0);
        end
      endcase
      carry  = carry & go;
      borrow = borrow & go;
      cmp    = go & (cnt_d == preset_q);
    end

    // Counter, disable and snapshot; commands win over counting
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        cnt_q   <= 24'h0;
        snap_q  <= 24'h0;
        dis_q   <= 1'b0;
        cause_q <= 3'h0;
      end else begin
        cause_q <= srcs;
        if (go) begin
          cnt_q <= cnt_d;
          if (mode == QEC_CM_NORECYC && (carry || borrow)) begin
            dis_q <= 1'b1;
          end
        end
        if (|(ld_c & ~cause_q) || (rl && xf == QEC_XF_LOAD)) begin
          cnt_q <= preset_q;
          dis_q <= 1'b0;
        end
        if ((~i_gate_mode[g] && |(rs_c & ~cause_q)) || clr == 2'h1) begin
          cnt_q <= 24'h0;
          dis_q <= 1'b0;
        end
        if (rl && xf == QEC_XF_SNAP) begin
          snap_q <= cnt_q;
        end
      end
    end

    // Status flags; events beat clears in the same cycle
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        {bt_q, ct_q, cpt_q, sign_q, err_q, up_q} <= 6'h01;
      end else begin
        bt_q   <= (bt_q & (clr != 2'h2)) ^ borrow;
        ct_q   <= (ct_q & (clr != 2'h2)) ^ carry;
        cpt_q  <= (cpt_q & (clr != 2'h2)) ^ cmp;
        sign_q <= borrow | (sign_q & ~carry & (clr != 2'h2));
        err_q  <= (err_q & (clr != 2'h3)) | bad;
        if (go) up_q <= up;
      end
    end

    // Flag outputs registered from the selected event
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        fa_q <= 1'b0;
        fb_q <= 1'b0;
      end else begin
        case (i_flag_a_sel[2*g +: 2])
          2'h0:    fa_q <= carry;
          2'h1:    fa_q <= cmp;
          2'h2:    fa_q <= carry | borrow;
          default: fa_q <= i_enc_idx[g];
        endcase
        case (i_flag_b_sel[2*g +: 2])
          2'h0:    fb_q <= borrow;
          2'h1:    fb_q <= up_q;
          default: fb_q <= err_q;
        endcase
      end
    end

    // Divider factor, count and filtered A/B samples
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        psc_n_q <= 8'h00;
        psc_q   <= 8'h00;
        ab_q    <= 2'h0;
      end else begin
        if (rl && xf == QEC_XF_PSC) begin
          psc_n_q <= preset_q[7:0];
        end
        if (fbc_tick) begin
          psc_q <= (psc_q == 8'h00) ? psc_n_q : psc_q - 8'h01;
        end
        if (sample) begin
          ab_q <= {i_enc_a[g], i_enc_b[g]};
        end
      end
    end

    // Mode byte, reload value and byte pointer
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        cmr_q    <= `QEC_CMR_RESET;
        preset_q <= 24'h0;
        bp_q     <= 2'h0;
      end else begin
        if (ctl_wr[g] && qec_regsel_t'(i_wdata[`QEC_CMD_REG_HI:
            `QEC_CMD_REG_LO]) == QEC_REG_MODE) begin
          cmr_q <= i_wdata;
        end
        if (dat_wr[g]) begin
          preset_q[8*bp_q +: 8] <= i_wdata;
        end
        if (dat_wr[g] || dat_rd[g]) begin
          bp_q <= (bp_q == `QEC_BP_LAST) ? 2'h0 : bp_q + 2'h1;
        end
        if (rl && i_wdata[`QEC_RL_BP]) begin
          bp_q <= 2'h0;
        end
      end
    end

    assign flag_byte[g] = {2'h0, up_q, err_q, sign_q, cpt_q, ct_q, bt_q};
    assign data_byte[g] = snap_q[8*bp_q +: 8];
    assign o_flag_output_a[g] = fa_q;
    assign o_flag_output_b[g] = fb_q;
  end

endmodule : qec_ctrl

/* qec_consts.svh */
// Offsets, field positions and limits of the encoder counter control block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef QEC_CONSTS_SVH
`define QEC_CONSTS_SVH
// ==========================================================
// Port offsets (byte addresses inside the 16-byte window)
`define QEC_OFS_DATA0     4'h0
`define QEC_OFS_PAIR_STEP 4'h2
`define QEC_OFS_PAIR_MASK 4'hE
`define QEC_OFS_CTRL_BIT  0
`define QEC_OFS_IRQ_SRC   4'h8
`define QEC_OFS_IRQ_CLR   4'hC
// ==========================================================
// Command byte fields
`define QEC_CMD_BOTH      7
`define QEC_CMD_REG_HI    6
`define QEC_CMD_REG_LO    5
`define QEC_RL_BP         0
`define QEC_RL_CLR_HI     2
`define QEC_RL_CLR_LO     1
`define QEC_RL_XFR_HI     4
`define QEC_RL_XFR_LO     3
`define QEC_CM_BCD        0
`define QEC_CM_MODE_HI    2
`define QEC_CM_MODE_LO    1
`define QEC_CM_QUAD_HI    4
`define QEC_CM_QUAD_LO    3
`define QEC_CMR_RESET     8'h00
// ==========================================================
// Counter limits and byte pointer
`define QEC_BIN_MAX       24'hFFFFFF
`define QEC_BCD_MAX       24'h999999
`define QEC_BCD_DIGITS    6
`define QEC_BCD_NINE      4'h9
`define QEC_BP_LAST       2'h2
`endif

/* qec_pkg.sv */
// Types shared by the encoder counter control block.
// Assumes nothing of its surroundings.
package qec_pkg;
  // ==========================================================
  // Register select held in command bits 6:5
  typedef enum logic [1:0] {
    QEC_REG_RESET_LOAD = 2'h0,
    QEC_REG_MODE       = 2'h1,
    QEC_REG_IO_CTRL    = 2'h2,
    QEC_REG_INDEX_CTRL = 2'h3
  } qec_regsel_t;
  // Count boundary behaviour
  typedef enum logic [1:0] {
    QEC_CM_NORMAL   = 2'h0,
    QEC_CM_RANGE    = 2'h1,
    QEC_CM_NORECYC  = 2'h2,
    QEC_CM_MODULO   = 2'h3
  } qec_count_mode_t;
  // Encoder count multiplication
  typedef enum logic [1:0] {
    QEC_Q_NONQUAD = 2'h0,
    QEC_Q_X1      = 2'h1,
    QEC_Q_X2      = 2'h2,
    QEC_Q_X4      = 2'h3
  } qec_quad_t;
  // Transfer field of a reset/load command
  typedef enum logic [1:0] {
    QEC_XF_NOP  = 2'h0,
    QEC_XF_LOAD = 2'h1,
    QEC_XF_SNAP = 2'h2,
    QEC_XF_PSC  = 2'h3
  } qec_xfer_t;
endpackage : qec_pkg

/* qec_ctrl_sva.sv */
// Checker for the register port and shared interrupt of qec_ctrl.
// Assumes it is bound to qec_ctrl and sees only that module's ports.
module qec_ctrl_chk #(
  parameter int NUM_AXES = 4            // Axis count of the bound design
) (
  input wire logic                  i_clk,
  input wire logic                  i_reset,
  input wire logic [3:0]            i_addr,
  input wire logic                  i_wr,
  input wire logic                  i_rd,
  input wire logic [7:0]            o_rdata,
  input wire logic [2*NUM_AXES-1:0] i_flag_a_sel,
  input wire logic [3*NUM_AXES-1:0] i_irq_cause_jumper,
  input wire logic [NUM_AXES-1:0]   o_flag_output_a,
  input wire logic                  o_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // Helpers
  logic clr_acc;                        // Any access to the clear offset
  assign clr_acc = (i_rd || i_wr) && (i_addr == 4'hC);
  sequence s_src_rd;                    // Read of the source nibble
    i_rd && (i_addr == 4'h8);
  endsequence
  sequence s_ctl_rd;                    // Read of a control offset
    i_rd && (i_addr[3:2] == 2'h0) && i_addr[0];
  endsequence
  // ==========================================================
  // Properties
  property p_src_nib;
    s_src_rd |=> (o_rdata[7:4] == 4'h0) &&
                 ((o_rdata[3:0] != 4'h0) == $past(o_irq));
  endproperty
  a_src_nib: assert property (p_src_nib)
    else $error("source read does not match request line");
  property p_clr_zero;
    i_rd && (i_addr == 4'hC) |=> o_rdata == 8'h00;
  endproperty
  a_clr_zero: assert property (p_clr_zero)
    else $error("clear offset read not zero");
  property p_irq_fall;
    $fell(o_irq) |-> $past(clr_acc);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("request dropped without a clear access");
  property p_irq_hold;
    o_irq && !clr_acc |=> o_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("request not held until cleared");
  property p_irq_cause;
    $rose(o_irq) |-> $past(|i_irq_cause_jumper);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("request raised with no cause enabled");
  property p_flag_byte;
    s_ctl_rd |=> o_rdata[7:6] == 2'h0;
  endproperty
  a_flag_byte: assert property (p_flag_byte)
    else $error("flag byte upper bits not zero");
  property p_rd_hold;
    !i_rd |=> $stable(o_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  property p_carry_pulse;
    (i_flag_a_sel[1:0] == 2'h0) && o_flag_output_a[0] |=>
      !o_flag_output_a[0];
  endproperty
  a_carry_pulse: assert property (p_carry_pulse)
    else $error("carry pulse longer than one cycle");
endmodule : qec_ctrl_chk

bind qec_ctrl qec_ctrl_chk #(.NUM_AXES(NUM_AXES)) chk_u (
  .i_clk              (i_clk),
  .i_reset            (i_reset),
  .i_addr             (i_addr),
  .i_wr               (i_wr),
  .i_rd               (i_rd),
  .o_rdata            (o_rdata),
  .i_flag_a_sel       (i_flag_a_sel),
  .i_irq_cause_jumper (i_irq_cause_jumper),
  .o_flag_output_a    (o_flag_output_a),
  .o_irq              (o_irq)
);

/* qec_enc_model.sv */
// Behavioural incremental encoder on the X axis; other axes stay idle.
// Assumes the caller enters step at a rising edge of i_clk.
module qec_enc_model #(
  parameter int HOLD = 8                // Cycles each line state is held
) (
  input  wire logic i_clk,
  output logic [3:0] o_enc_a,
  output logic [3:0] o_enc_b,
  output logic [3:0] o_enc_idx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase_q = 2'h0;           // Gray position 00,10,11,01
  // Long hold keeps every state visible to any sample strobe that comes at least every 8 cycles
  assign o_enc_a   = {3'h0, phase_q[1] ^ phase_q[0]};
  assign o_enc_b   = {3'h0, phase_q[1]};
  assign o_enc_idx = 4'h0;
  // ==========================================================
  // One quadrature edge per step, forward when up is set
  task automatic step(input logic up, input int n);
    for (int k = 0; k < n; k++) begin
      phase_q <= up ? phase_q + 2'h1 : phase_q - 2'h1;
      repeat (HOLD) @(posedge i_clk);
    end
  endtask : step
endmodule : qec_enc_model

/* qec_ctrl_tb_top.sv */
// Self-checking bench for the encoder counter control block.
// Assumes qec_ctrl with its bound checker and the X-axis encoder model.
module qec_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Signals
  logic        clk     = 1'b0;          // 250 MHz bus clock
  logic        rst     = 1'b1;          // Synchronous reset
  logic [3:0]  addr    = 4'h0;          // Port offset
  logic        wr      = 1'b0;          // Write strobe
  logic        rd      = 1'b0;          // Read strobe
  logic [7:0]  wdata   = 8'h00;         // Write data
  logic        sel     = 1'b0;          // Axis pick inside a pair
  logic        fbc     = 1'b0;          // Filter base clock
  logic [11:0] irq_jmp = 12'h000;       // Interrupt cause enables
  logic [7:0]  fbs     = 8'h01;         // Flag B selects: X shows direction
  logic [7:0]  rdata;                   // Read data
  logic [3:0]  ea, eb, ei, fa, fb;      // Encoder lines and flags
  logic        irq;                     // Shared request
  int          fail_count = 0;          // Mismatches
  int          num_checks = 0;          // Comparisons
  always #2 clk = ~clk;
  always @(posedge clk) fbc <= ~fbc;
  qec_ctrl #(.NUM_AXES(4)) dut_u (
    .i_clk(clk), .i_reset(rst), .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_wdata(wdata), .o_rdata(rdata), .i_axis_sel(sel),
    .i_filter_base_clock(fbc), .i_enc_a(ea), .i_enc_b(eb),
    .i_enc_idx(ei), .i_flag_a_sel(8'h00), .i_flag_b_sel(fbs),
    .i_gate_mode(4'h0), .i_load_cause_jumper(12'h000),
    .i_reset_cause_jumper(12'h000), .i_irq_cause_jumper(irq_jmp),
    .o_flag_output_a(fa), .o_flag_output_b(fb), .o_irq(irq));
  qec_enc_model enc_u (.i_clk(clk), .o_enc_a(ea), .o_enc_b(eb),
    .o_enc_idx(ei));
  // ==========================================================
  // Access tasks; each starts and ends at a rising edge
  task automatic chk(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  // Idle cycle after the strobe keeps two writes from one time step
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
    @(posedge clk);
  endtask : rd_chk
  task automatic irq_chk(input logic e);
    #1 chk("irq", {7'h00, e}, {7'h00, irq});
    @(posedge clk);
  endtask : irq_chk
  // Pointer reset, then low, middle and high reload bytes
  task automatic load_rl(input logic s, input logic [23:0] v);
    sel <= s;
    wr_reg(4'h1, 8'h01);
    for (int k = 0; k < 3; k++) wr_reg(4'h0, v[8*k +: 8]);
  endtask : load_rl
  // Snapshot by the given command, then read it back low byte first
  task automatic snap_chk(input logic s, input logic [7:0] c,
                          input logic [23:0] e);
    sel <= s;
    wr_reg(4'h1, c);
    wr_reg(4'h1, 8'h01);
    for (int k = 0; k < 3; k++) rd_chk(4'h0, e[8*k +: 8]);
  endtask : snap_chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(4'h1, 8'h20);
    rd_chk(4'h8, 8'h00);
    // Pair commands, then a command with the I/O control register select
    load_rl(1'b1, 24'h000005);
    load_rl(1'b0, 24'h000007);
    wr_reg(4'h1, 8'h88);
    wr_reg(4'h1, 8'h42);
    snap_chk(1'b1, 8'h90, 24'h000005);
    snap_chk(1'b0, 8'h10, 24'h000007);
    wr_reg(4'h1, 8'h02);
    snap_chk(1'b0, 8'h10, 24'h000000);
    snap_chk(1'b1, 8'h10, 24'h000005);
    // Overflow at the top of the 24-bit range raises the request
    load_rl(1'b0, 24'hFFFFFE);
    wr_reg(4'h1, 8'h38);
    wr_reg(4'h1, 8'h08);
    wr_reg(4'h1, 8'h04);
    irq_jmp <= 12'h004;
    enc_u.step(1'b1, 2);
    repeat (8) @(posedge clk);
    irq_chk(1'b1);
    rd_chk(4'h8, 8'h01);
    rd_chk(4'h1, 8'h22);
    snap_chk(1'b0, 8'h10, 24'h000000);
    irq_chk(1'b1);
    wr_reg(4'hC, 8'h00);
    irq_chk(1'b0);
    rd_chk(4'hC, 8'h00);
    rd_chk(4'h8, 8'h00);
    // Underflow: borrow and sign, but borrow is not an enabled cause
    wr_reg(4'h1, 8'h04);
    enc_u.step(1'b0, 1);
    repeat (8) @(posedge clk);
    rd_chk(4'h1, 8'h09);
    irq_chk(1'b0);
    chk("flag_b", 8'h00, {7'h00, fb[0]});
    snap_chk(1'b0, 8'h10, 24'hFFFFFF);
    // Decimal count carries from nine into the tens digit
    wr_reg(4'h1, 8'h39);
    load_rl(1'b0, 24'h000009);
    wr_reg(4'h1, 8'h08);
    enc_u.step(1'b1, 1);
    repeat (8) @(posedge clk);
    snap_chk(1'b0, 8'h10, 24'h000010);
    chk("flag_b", 8'h01, {7'h00, fb[0]});
    summarize();
  end
endmodule : qec_ctrl_tb_top
